// ### rtl/rfx_params.svh
// Purpose: constants for the receive link extractor
// Assumes: included by bare name from the rfx_fifo, rfx_destuff and rfx_top design files and the bench
// Notes: register indices are word indices; byte address is index times four
`ifndef RFX_PARAMS_SVH
`define RFX_PARAMS_SVH

// apb byte address width and word index width, in bits
`define RFX_PADDR_W 14
`define RFX_IDX_W 12

// register word indices
`define RFX_IDX_RXBYTE 12'h028
`define RFX_IDX_MATCH1 12'h029
`define RFX_IDX_MATCH2 12'h02a
`define RFX_IDX_MASK 12'h06f
`define RFX_IDX_STATUS 12'h020
`define RFX_IDX_CTRL 12'h01a

// status and mask bit positions
`define RFX_ST_FULL 4
`define RFX_ST_MATCH 2
`define RFX_ST_ABORT 1
// writable bits of status and mask
`define RFX_ST_BITS 8'h16

// control bit positions
`define RFX_CT_DESTUFF 0
`define RFX_CT_ESF 3
`define RFX_CT_BITS 8'h09

// reset values
`define RFX_RST_REG 8'h00
`define RFX_RST_WORD 32'h0000_0000

// link stream counts
`define RFX_BYTE_BITS 8
`define RFX_STUFF_ONES 4'h5
`define RFX_ABORT_LAST 4'h7
`define RFX_ONES_MAX 4'h8
`define RFX_LAST_BIT 3'h7

// buffer shape
`define RFX_FIFO_DEPTH 8

`endif

// ### rtl/rfx_pkg.sv
// Purpose: shared types of the receive link extractor
// Assumes: nothing imported, every use is scoped
// Notes: constants live in rfx_params.svh
package rfx_pkg;

	typedef logic [7:0] rfx_byte_t;

	// apb answer sequencer
	typedef enum logic {
		RFX_APB_IDLE,
		RFX_APB_ANSWER
	} rfx_apb_state_t;

endpackage : rfx_pkg

// ### rtl/rfx_bit_if.sv
// Purpose: carries destuffed link bits from the destuffer to the byte shifter
// Assumes: one clock, valid is a one-cycle pulse per kept bit
// Notes: abort pulses once per run of eight ones
`timescale 1ns/1ps
interface rfx_bit_if;
	logic valid;
	logic data;
	logic abort;

	modport src (output valid, output data, output abort);
	modport dst (input valid, input data, input abort);
endinterface : rfx_bit_if

// ### rtl/rfx_fifo.sv
// Purpose: byte buffer between the shifter and the host byte register
// Assumes: single clock, valid and ready on both sides
// Notes: full and empty are registered so they can drive ports directly
`timescale 1ns/1ps
`include "rfx_params.svh"
module rfx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `RFX_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [AW:0] count_ff, nxt_count;
	logic full_ff, nxt_full, empty_ff, nxt_empty;
	logic push, pop;

	// handshakes only fire on honest flags
	assign push = inValid & ~full_ff;
	assign pop = outReady & ~empty_ff;
	assign inReady = ~full_ff;
	assign outValid = ~empty_ff;
	assign outData = mem[rdPtr_ff];
	assign full = full_ff;

	// pointer and occupancy next values
	always_comb
	begin
		nxt_wrPtr = wrPtr_ff;
		nxt_rdPtr = rdPtr_ff;
		nxt_count = count_ff;
		if (push)
		begin
			nxt_wrPtr = (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
		end
		if (pop)
		begin
			nxt_rdPtr = (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
		end
		if (push && !pop)
		begin
			nxt_count = count_ff + 1'b1;
		end
		else if (pop && !push)
		begin
			nxt_count = count_ff - 1'b1;
		end
		nxt_full = (nxt_count == (AW+1)'(DEPTH));
		nxt_empty = (nxt_count == '0);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
			full_ff <= 1'b0;
			empty_ff <= 1'b1;
		end
		else
		begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
			full_ff <= nxt_full;
			empty_ff <= nxt_empty;
		end
	end

	// storage needs no reset, empty guards stale words
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wrPtr_ff] <= inData;
		end
	end

endmodule : rfx_fifo

// ### rtl/rfx_destuff.sv
// Purpose: zero destuffer and abort detector on the raw link stream
// Assumes: bitEn is a one-cycle strobe per recovered link bit
// Notes: ones are counted on the raw stream, before any zero is dropped
`timescale 1ns/1ps
`include "rfx_params.svh"
module rfx_destuff (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bitEn,
	input wire logic bitIn,
	input wire logic destuffEn,
	rfx_bit_if.src bitOut
);
	logic [3:0] onesCnt_ff, nxt_onesCnt;
	logic valid_ff, nxt_valid, data_ff, nxt_data, abort_ff, nxt_abort;
	logic dropZero;

	// only after exactly five ones, six or more keep it
	assign dropZero = destuffEn & ~bitIn & (onesCnt_ff == `RFX_STUFF_ONES);

	// run counter saturates so long idle ones do not wrap
	always_comb
	begin
		nxt_onesCnt = onesCnt_ff;
		nxt_valid = 1'b0;
		nxt_data = data_ff;
		nxt_abort = 1'b0;
		if (bitEn)
		begin
			nxt_data = bitIn;
			nxt_valid = ~dropZero;
			nxt_abort = bitIn & (onesCnt_ff == `RFX_ABORT_LAST);
			if (!bitIn)
			begin
				nxt_onesCnt = 4'h0;
			end
			else if (onesCnt_ff != `RFX_ONES_MAX)
			begin
				nxt_onesCnt = onesCnt_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			onesCnt_ff <= 4'h0;
			valid_ff <= 1'b0;
			data_ff <= 1'b0;
			abort_ff <= 1'b0;
		end
		else
		begin
			onesCnt_ff <= nxt_onesCnt;
			valid_ff <= nxt_valid;
			data_ff <= nxt_data;
			abort_ff <= nxt_abort;
		end
	end

	assign bitOut.valid = valid_ff;
	assign bitOut.data = data_ff;
	assign bitOut.abort = abort_ff;

endmodule : rfx_destuff

// ### rtl/rfx_top.sv
// Purpose: receive facility link extractor with apb register access
// Assumes: link bits and strobe come from framer logic on clk
// Notes: a byte buffer sits between shifter and host byte register
`timescale 1ns/1ps
`include "rfx_params.svh"
module rfx_top (
	input wire logic clk,
	input wire logic rst_n,
	// link side
	input wire logic linkBitEn,
	input wire logic facilityLinkBit,
	input wire logic signalingFrameBit,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`RFX_PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host side
	output logic secondInterruptN,
	output logic linkBufferFull
);
	// bus state
	rfx_pkg::rfx_apb_state_t apbState_ff, nxt_apbState;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;

	// software visible registers
	rfx_pkg::rfx_byte_t ctrl_ff, nxt_ctrl;
	rfx_pkg::rfx_byte_t mask_ff, nxt_mask;
	rfx_pkg::rfx_byte_t match1_ff, nxt_match1;
	rfx_pkg::rfx_byte_t match2_ff, nxt_match2;
	rfx_pkg::rfx_byte_t status_ff, nxt_status;
	rfx_pkg::rfx_byte_t rxByte_ff, nxt_rxByte;
	logic byteEmpty_ff, nxt_byteEmpty;
	logic intN_ff, nxt_intN;
	logic bufFull_ff, nxt_bufFull;

	// shifter state
	rfx_pkg::rfx_byte_t shift_ff, nxt_shift;
	logic [2:0] bitCnt_ff, nxt_bitCnt;

	// internal strobes
	logic linkBit;
	logic [`RFX_IDX_W-1:0] idx;
	logic access, done, wrDone, rdDone;
	logic hitRx, hitM1, hitM2, hitMask, hitStatus, hitCtrl, hitAny;
	logic byteDone;
	rfx_pkg::rfx_byte_t doneByte;
	logic fifoOutValid, fifoFull, loadByte;
	rfx_pkg::rfx_byte_t fifoOut;
	logic matchHit;
	rfx_pkg::rfx_byte_t setBits, clrBits;

	rfx_bit_if bitLink ();

	// source select by framing mode; both inputs are already on clk
	assign linkBit = ctrl_ff[`RFX_CT_ESF] ? facilityLinkBit : signalingFrameBit;

	// destuffer and abort detector on the raw stream
	rfx_destuff u_destuff (
		.clk(clk),
		.rst_n(rst_n),
		.bitEn(linkBitEn),
		.bitIn(linkBit),
		.destuffEn(ctrl_ff[`RFX_CT_DESTUFF]),
		.bitOut(bitLink)
	);

	// shifter: new bit enters at the top, oldest moves toward bit 0
	always_comb
	begin
		nxt_shift = shift_ff;
		nxt_bitCnt = bitCnt_ff;
		byteDone = 1'b0;
		doneByte = {bitLink.data, shift_ff[7:1]};
		// only kept bits advance the count
		if (bitLink.valid)
		begin
			// serial shift of each kept bit
			nxt_shift = doneByte;
			// eighth kept bit completes a byte
			if (bitCnt_ff == `RFX_LAST_BIT)
			begin
				nxt_bitCnt = 3'h0;
				byteDone = 1'b1;
			end
			else
			begin
				nxt_bitCnt = bitCnt_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_ff <= `RFX_RST_REG;
			bitCnt_ff <= 3'h0;
		end
		else
		begin
			shift_ff <= nxt_shift;
			bitCnt_ff <= nxt_bitCnt;
		end
	end

	// completed bytes queue here; a byte arriving when full is lost,
	// since the line cannot be stalled, and linkBufferFull warns of it
	rfx_fifo #(
		.WIDTH(`RFX_BYTE_BITS),
		.DEPTH(`RFX_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(byteDone),
		.inReady(),
		.inData(doneByte),
		.outValid(fifoOutValid),
		.outReady(loadByte),
		.outData(fifoOut),
		.full(fifoFull)
	);

	// host register takes the next byte only once the last was read,
	// so a slow host stalls the drain and the buffer really fills
	assign loadByte = fifoOutValid & byteEmpty_ff;

	assign matchHit = (fifoOut == match1_ff) | (fifoOut == match2_ff);

	// apb decode on word index; low address bits are ignored
	assign idx = paddr[`RFX_PADDR_W-1:2];
	assign hitRx = (idx == `RFX_IDX_RXBYTE);
	assign hitM1 = (idx == `RFX_IDX_MATCH1);
	assign hitM2 = (idx == `RFX_IDX_MATCH2);
	assign hitMask = (idx == `RFX_IDX_MASK);
	assign hitStatus = (idx == `RFX_IDX_STATUS);
	assign hitCtrl = (idx == `RFX_IDX_CTRL);
	assign hitAny = hitRx | hitM1 | hitM2 | hitMask | hitStatus | hitCtrl;
	assign access = psel & penable;
	// transfer ends at the edge where pready is seen high
	assign done = access & pready_ff;
	assign wrDone = done & pwrite & hitAny;
	assign rdDone = done & ~pwrite & hitAny;

	// apb answer: one wait state, then pready with data and error
	always_comb
	begin
		nxt_apbState = apbState_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		case (apbState_ff)
			rfx_pkg::RFX_APB_IDLE:
			begin
				if (access)
				begin
					nxt_apbState = rfx_pkg::RFX_APB_ANSWER;
					nxt_pready = 1'b1;
					nxt_pslverr = ~hitAny;
					nxt_prdata = `RFX_RST_WORD;
					if (!pwrite)
					begin
						if (hitRx)
						begin
							nxt_prdata[7:0] = rxByte_ff;
						end
						if (hitM1)
						begin
							nxt_prdata[7:0] = match1_ff;
						end
						if (hitM2)
						begin
							nxt_prdata[7:0] = match2_ff;
						end
						if (hitMask)
						begin
							nxt_prdata[7:0] = mask_ff;
						end
						if (hitStatus)
						begin
							nxt_prdata[7:0] = status_ff;
						end
						if (hitCtrl)
						begin
							nxt_prdata[7:0] = ctrl_ff;
						end
					end
				end
			end
			rfx_pkg::RFX_APB_ANSWER:
			begin
				// pready drops after one cycle, the master has finished
				nxt_apbState = rfx_pkg::RFX_APB_IDLE;
			end
			default:
			begin
				nxt_apbState = rfx_pkg::RFX_APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			apbState_ff <= rfx_pkg::RFX_APB_IDLE;
			prdata_ff <= `RFX_RST_WORD;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			apbState_ff <= nxt_apbState;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// control and compare registers; reserved bits stay zero
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		nxt_match1 = match1_ff;
		nxt_match2 = match2_ff;
		if (wrDone && hitCtrl)
		begin
			nxt_ctrl = pwdata[7:0] & `RFX_CT_BITS;
		end
		if (wrDone && hitMask)
		begin
			nxt_mask = pwdata[7:0] & `RFX_ST_BITS;
		end
		if (wrDone && hitM1)
		begin
			nxt_match1 = pwdata[7:0];
		end
		if (wrDone && hitM2)
		begin
			nxt_match2 = pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_ff <= `RFX_RST_REG;
			mask_ff <= `RFX_RST_REG;
			match1_ff <= `RFX_RST_REG;
			match2_ff <= `RFX_RST_REG;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			mask_ff <= nxt_mask;
			match1_ff <= nxt_match1;
			match2_ff <= nxt_match2;
		end
	end

	// host byte, status flags and interrupt pin
	always_comb
	begin
		nxt_rxByte = rxByte_ff;
		nxt_byteEmpty = byteEmpty_ff;
		setBits = `RFX_RST_REG;
		clrBits = `RFX_RST_REG;
		// reading the byte frees the register for the next one
		if (rdDone && hitRx)
		begin
			nxt_byteEmpty = 1'b1;
		end
		if (loadByte)
		begin
			nxt_rxByte = fifoOut;
			nxt_byteEmpty = 1'b0;
			setBits[`RFX_ST_FULL] = 1'b1;
			setBits[`RFX_ST_MATCH] = matchHit;
		end
		// abort from the raw run counter
		setBits[`RFX_ST_ABORT] = bitLink.abort;
		// write one to clear; a set in the same cycle wins
		if (wrDone && hitStatus)
		begin
			clrBits = pwdata[7:0] & `RFX_ST_BITS;
		end
		nxt_status = (status_ff & ~clrBits) | setBits;
		// masked flags pull the pin low
		nxt_intN = ~|(nxt_status & mask_ff);
		nxt_bufFull = fifoFull;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxByte_ff <= `RFX_RST_REG;
			byteEmpty_ff <= 1'b1;
			status_ff <= `RFX_RST_REG;
			intN_ff <= 1'b1;
			bufFull_ff <= 1'b0;
		end
		else
		begin
			rxByte_ff <= nxt_rxByte;
			byteEmpty_ff <= nxt_byteEmpty;
			status_ff <= nxt_status;
			intN_ff <= nxt_intN;
			bufFull_ff <= nxt_bufFull;
		end
	end

	// every output comes from a flip-flop
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign secondInterruptN = intN_ff;
	assign linkBufferFull = bufFull_ff;

endmodule : rfx_top

// ### sim/rfx_asserts.sv
// Purpose: port checker for rfx_top
// Assumes: one clock, async active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module rfx_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic linkBitEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic secondInterruptN,
	input wire logic linkBufferFull
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// bus answer is a single-cycle pulse after one wait state
	property p_rdyOne;
		pready |=> !pready;
	endproperty
	a_rdyOne: assert property (p_rdyOne)
		else $error("pready held past one cycle");
	property p_rdyWait;
		psel && penable && !pready |=> pready;
	endproperty
	a_rdyWait: assert property (p_rdyWait)
		else $error("pready missing after access edge");
	property p_idle;
		!psel |=> !pready && !pslverr;
	endproperty
	a_idle: assert property (p_idle)
		else $error("answer without a request");
	property p_errZero;
		pready && pslverr |-> prdata == 32'h0;
	endproperty
	a_errZero: assert property (p_errZero)
		else $error("refused access returned data");
	property p_upper;
		pready |-> prdata[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper read bits not zero");
	property p_intFall;
		$fell(secondInterruptN) |-> $past(linkBitEn, 2) || $past(linkBitEn, 3) ||
			$past(pready, 2);
	endproperty
	a_intFall: assert property (p_intFall)
		else $error("interrupt fell without cause");
	property p_intRise;
		$rose(secondInterruptN) |-> ($past(pready) && $past(pwrite)) ||
			($past(pready, 2) && $past(pwrite, 2));
	endproperty
	a_intRise: assert property (p_intRise)
		else $error("interrupt rose without a write");
	property p_fullRise;
		$rose(linkBufferFull) |-> $past(linkBitEn, 3);
	endproperty
	a_fullRise: assert property (p_fullRise)
		else $error("buffer full without a link bit");
	property p_fullFall;
		$fell(linkBufferFull) |-> $past(pready, 2) || $past(pready, 3) || $past(pready, 4);
	endproperty
	a_fullFall: assert property (p_fullFall)
		else $error("buffer full dropped without a read");

	c_int: cover property ($fell(secondInterruptN));
	c_err: cover property (pready && pslverr);
	c_full: cover property ($rose(linkBufferFull));
endmodule : rfx_asserts

bind rfx_top rfx_asserts chk (.clk(clk), .rst_n(rst_n), .linkBitEn(linkBitEn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.secondInterruptN(secondInterruptN), .linkBufferFull(linkBufferFull));

// ### sim/rfx_link_src.sv
// Purpose: framer-side model handing link bits to the extractor
// Assumes: one request per bit, raised for one cycle
// Notes: lines toggle outside strobes so stale bits never pass as valid
`timescale 1ns/1ps
module rfx_link_src (
	input wire logic clk,
	input wire logic sendReq,
	input wire logic sendBit,
	input wire logic useEsf,
	output logic linkBitEn,
	output logic facilityLinkBit,
	output logic signalingFrameBit
);
	initial {linkBitEn, facilityLinkBit, signalingFrameBit} = 3'h0;
	// only the selected line carries the bit, and only with the strobe
	always @(posedge clk)
	begin
		linkBitEn <= sendReq;
		facilityLinkBit <= (sendReq && useEsf) ? sendBit : ~facilityLinkBit;
		signalingFrameBit <= (sendReq && !useEsf) ? sendBit : ~signalingFrameBit;
	end
endmodule : rfx_link_src

// ### sim/rx_facility_link_extractor_bench.sv
// Purpose: self-checking bench for the receive link extractor
// Assumes: apb master and link model share clk, fixed seed
// Notes: buffer holds the host byte plus eight queued bytes
`timescale 1ns/1ps
`include "rfx_params.svh"
module rx_facility_link_extractor_bench;
	localparam logic [13:0] aCtl = {`RFX_IDX_CTRL, 2'h0};
	localparam logic [13:0] aSt = {`RFX_IDX_STATUS, 2'h0};
	localparam logic [13:0] aMsk = {`RFX_IDX_MASK, 2'h0};
	localparam logic [13:0] aRx = {`RFX_IDX_RXBYTE, 2'h0};
	localparam logic [13:0] aM1 = {`RFX_IDX_MATCH1, 2'h0};
	localparam logic [13:0] aM2 = {`RFX_IDX_MATCH2, 2'h0};
	logic [13:0] rAddr [5] = '{aCtl, aSt, aMsk, aM1, aM2};
	logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [13:0] paddr = 14'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, intN, full, bitEn, facBit, sigBit, err;
	logic sendReq = 1'h0, sendBit = 1'h0, useEsf = 1'h0, destuffOn = 1'h0;
	logic [8:0] d4 = 9'h01f;
	int mismatches = 0, tests_run = 0, run = 0;
	rfx_pkg::rfx_byte_t m1, m2, q[$];

	rfx_link_src link (.clk(clk), .sendReq(sendReq), .sendBit(sendBit), .useEsf(useEsf),
		.linkBitEn(bitEn), .facilityLinkBit(facBit), .signalingFrameBit(sigBit));
	rfx_top dut (.clk(clk), .rst_n(rst_n), .linkBitEn(bitEn), .facilityLinkBit(facBit),
		.signalingFrameBit(sigBit), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .secondInterruptN(intN), .linkBufferFull(full));

	// 20 MHz clock
	initial
	begin
		forever #25 clk = ~clk;
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task chkw(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chkw

	task chkp(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t pin %b expected %b", $time, got, exp);
		end
	endtask : chkp

	task timedOut;
		mismatches++;
		$display("[FAIL] %0t wait ran out", $time);
		tally_and_finish();
	endtask : timedOut

	// request held until pready is seen at a rising edge
	task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// pready is judged, and read data taken, only at a rising edge
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (pready === 1'h1)
				break;
		end
		if (n >= 20)
			timedOut();
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// random spacing between strobes models a slow framer
	task sendRaw(input logic b);
		@(posedge clk);
		sendReq <= 1'h1;
		sendBit <= b;
		@(posedge clk);
		sendReq <= 1'h0;
		repeat ($urandom_range(3)) @(posedge clk);
	endtask : sendRaw

	task sendByte(input rfx_pkg::rfx_byte_t b);
		for (int i = 0; i < 8; i++)
		begin
			sendRaw(b[i]);
			run = b[i] ? run + 1 : 0;
			if (run == 5 && destuffOn)
			begin
				sendRaw(1'h0);
				run = 0;
			end
		end
	endtask : sendByte

	function automatic logic [31:0] expStatus(input rfx_pkg::rfx_byte_t b);
		return (b === m1 || b === m2) ? 32'h14 : 32'h10;
	endfunction : expStatus

	task checkByte(input rfx_pkg::rfx_byte_t b, input logic [31:0] extra);
		int n;
		for (n = 0; n < 60 && intN !== 1'h0; n++)
			@(negedge clk);
		if (n >= 60)
			timedOut();
		// host reads each byte before the next one lands
		apb(1'h0, aSt, 32'h0);
		chkw(rd, expStatus(b) | extra);
		apb(1'h0, aRx, 32'h0);
		chkw(rd, {24'h0, b});
		apb(1'h1, aSt, 32'h16);
		@(negedge clk);
		chkp(intN, 1'h1);
	endtask : checkByte

	initial
	begin
		void'($urandom(58687));
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		foreach (rAddr[i])
		begin
			apb(1'h0, rAddr[i], 32'h0);
			chkw(rd, 32'h0);
			chkp(err, 1'h0);
		end
		// unmapped place and read-only byte
		apb(1'h0, 14'h0, 32'h0);
		chkw(rd, 32'h0);
		chkp(err, 1'h1);
		apb(1'h1, aRx, 32'h5a);
		chkp(err, 1'h0);
		apb(1'h1, aMsk, 32'hff);
		apb(1'h0, aMsk, 32'h0);
		chkw(rd, 32'h16);
		// host keeps the destuffer on for the link
		apb(1'h1, aCtl, 32'hff);
		apb(1'h0, aCtl, 32'h0);
		chkw(rd, 32'h09);
		useEsf <= 1'h1;
		destuffOn = 1'h1;
		m1 = 8'($urandom);
		m2 = 8'($urandom);
		apb(1'h1, aM1, {24'h0, m1});
		apb(1'h1, aM2, {24'h0, m2});
		q = '{m1, m2, 8'hff, 8'h7e, 8'h3f, 8'h00};
		repeat (6) q.push_back(8'($urandom));
		foreach (q[i])
		begin
			sendByte(q[i]);
			checkByte(q[i], 32'h0);
		end
		// eight raw ones, then a zero kept after six ones
		repeat (8) sendRaw(1'h1);
		checkByte(8'hff, 32'h02);
		sendRaw(1'h0);
		repeat (6) sendRaw(1'h1);
		sendRaw(1'h0);
		checkByte(8'h7e, 32'h0);
		apb(1'h1, aCtl, 32'h01);
		useEsf <= 1'h0;
		for (int i = 0; i < 9; i++)
			sendRaw(d4[i]);
		checkByte(8'h1f, 32'h0);
		// fill the buffer with interrupts masked, then drain it
		apb(1'h1, aMsk, 32'h0);
		apb(1'h1, aCtl, 32'h08);
		useEsf <= 1'h1;
		destuffOn = 1'h0;
		q.delete();
		repeat (10) q.push_back(8'($urandom));
		foreach (q[i])
			sendByte(q[i]);
		repeat (4) @(negedge clk);
		chkp(full, 1'h1);
		chkp(intN, 1'h1);
		for (int i = 0; i < 9; i++)
		begin
			apb(1'h0, aRx, 32'h0);
			chkw(rd, {24'h0, q[i]});
		end
		repeat (4) @(negedge clk);
		chkp(full, 1'h0);
		tally_and_finish();
	end
endmodule : rx_facility_link_extractor_bench
